//--- ppm_pkg.sv
// Summary of operation
// - Static mode comes from configuration bits 7-4.
// - Run-time changes need bit 4 and 110/111.
// - Dynamic mode from extended control and qualifier.
// - Second-level registers reached by index and data.
// - Static codes: compatible, extended, EPP 1.7, 1.9.
// - Dynamic codes: compatible, extended, FIFO, ECP, EPP.
// - Interrupt and DMA routable to chosen lines.
// - Port active only while function enable set.
// - Reset floats handshake outputs, drives init low.
// - Data, status, control at 0-2; 3 undriven.
// - Data direction from control bit 5, mode.
// - Compatible mode drives lines, reads output latch.
// - Extended, direction 0: drive lines, read latch.
// - Extended, direction 1: read pins, latch only.
// - Data register and latch reset to zero.
// - Status register writes have no effect.
`default_nettype none

package ppm_pkg;

    // ==========================================================
    // Register offsets relative to the programmed base address.
    localparam logic [15:0] OFF_DATA = 16'h0000;
    localparam logic [15:0] OFF_STATUS = 16'h0001;
    localparam logic [15:0] OFF_CONTROL = 16'h0002;
    localparam logic [15:0] OFF_HOLE = 16'h0003;
    localparam logic [15:0] OFF_EXT_CTRL = 16'h0402;
    localparam logic [15:0] OFF_SL_INDEX = 16'h0403;
    localparam logic [15:0] OFF_SL_DATA = 16'h0404;

    // ==========================================================
    // Second-level qualifier register and its fields.
    localparam logic [7:0] SL_QUAL_IDX = 8'h02;
    localparam int QUAL_EPP_REV_BIT = 4;
    localparam int QUAL_COMPAT_BIT = 7;

    // ==========================================================
    // Control register fields.
    localparam int CTRL_STROBE = 0;
    localparam int CTRL_AUTOFEED = 1;
    localparam int CTRL_INIT = 2;
    localparam int CTRL_SELECT = 3;
    localparam int CTRL_IRQ_EN = 4;
    localparam int CTRL_DIR = 5;

    // ==========================================================
    // Reset values.
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h04;
    localparam logic [7:0] EXT_CTRL_RST = 8'h60;
    localparam logic [7:0] SL_RST = 8'h00;
    localparam logic [2:0] STATUS_LOW_ONES = 3'h7;
    localparam logic [1:0] CTRL_HIGH_ONES = 2'h3;

    // ==========================================================
    // Mode field codes in configuration and extended control.
    localparam logic [2:0] CFG_DYN_A = 3'h6;
    localparam logic [2:0] CFG_DYN_B = 3'h7;
    localparam logic [2:0] CFG_COMPAT = 3'h0;
    localparam logic [2:0] CFG_EXT = 3'h1;
    localparam logic [2:0] CFG_EPP17 = 3'h2;
    localparam logic [2:0] CFG_EPP19 = 3'h3;
    localparam logic [2:0] ECR_COMPAT = 3'h0;
    localparam logic [2:0] ECR_EXT = 3'h1;
    localparam logic [2:0] ECR_FIFO = 3'h2;
    localparam logic [2:0] ECR_ECP = 3'h3;
    localparam logic [2:0] ECR_EPP = 3'h4;

    // ==========================================================
    // Routing limits.
    localparam logic [3:0] IRQ_BAR_A = 4'h2;
    localparam logic [3:0] IRQ_BAR_B = 4'hd;
    localparam logic [3:0] IRQ_NONE = 4'h0;
    localparam int DMA_CHANS = 3;

    // Active operating mode of the port.
    typedef enum logic [2:0] {
        PPM_SPP_COMPAT = 3'b000,
        PPM_SPP_EXT = 3'b001,
        PPM_FIFO_OUT = 3'b010,
        PPM_EPP17 = 3'b011,
        PPM_EPP19 = 3'b100,
        PPM_ECP = 3'b101
    } ppm_mode_t;

    // Host bus pins, sampled together.
    typedef struct packed {
        logic rd_b;
        logic wr_b;
        logic [2:0] dack_b;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ppm_host_bus_t;

    // Peripheral status pins.
    typedef struct packed {
        logic busy;
        logic ack_b;
        logic paper_end;
        logic select;
        logic error_b;
    } ppm_status_pins_t;

    localparam ppm_host_bus_t HOST_IDLE = '{rd_b: 1'b1, wr_b: 1'b1,
        dack_b: 3'h7, addr: 16'h0000, wdata: 8'h00};

endpackage

`default_nettype wire

//--- ppm_sync.sv
`default_nettype none

// ==========================================================
// Two-stage synchroniser for pins from outside the clock domain.
module ppm_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // The first stage feeds only the second.
    always_comb begin
        meta_d = ce ? din : meta_q;
        sync_d = ce ? meta_q : sync_q;
    end

    // Both stages hold while the clock enable is low.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign dout = sync_q;

endmodule

`default_nettype wire

//--- ppm_fifo.sv
`default_nettype none

// ==========================================================
// Small write buffer with valid and ready on both sides.
module ppm_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("ppm_fifo depth must be a power of two of 2 or more");
    end

    logic [W-1:0] mem_q [DEPTH];
    logic [W-1:0] mem_d [DEPTH];
    logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [AW:0] count_q, count_d;
    logic push, pop;

    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data = mem_q[rd_ptr_q];
    assign push = ce & in_valid & in_ready;
    assign pop = ce & out_valid & out_ready;

    // Pointer and occupancy update; a full buffer refuses pushes.
    always_comb begin
        mem_d = mem_q;
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        count_d = count_q;
        if (push) begin
            mem_d[wr_ptr_q] = in_data;
            wr_ptr_d = wr_ptr_q + 1'b1;
        end
        if (pop) begin
            rd_ptr_d = rd_ptr_q + 1'b1;
        end
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    // Storage registers.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            mem_q <= mem_d;
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
        end
    end

    fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_b)
        count_q <= (AW+1)'(DEPTH))
        else $error("fifo occupancy above depth");

endmodule

`default_nettype wire

//--- ppm_port.sv
`default_nettype none

// ==========================================================
// Parallel port mode selection and standard register front end.
module ppm_port #(
    parameter int SL_IDX_W = 3,
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [15:0] base_addr,
    input wire logic [3:0] cfg_mode,
    input wire logic function_enable_one,
    input wire logic [3:0] irq_route,
    input wire logic [1:0] dma_route,
    input wire ppm_pkg::ppm_host_bus_t host_pins,
    output logic [7:0] host_data_o,
    output logic host_data_oe,
    input wire ppm_pkg::ppm_status_pins_t status_pins,
    input wire logic [7:0] port_data_lines_i,
    output logic [7:0] port_data_lines_o,
    output logic port_data_lines_oe,
    output logic data_strobe_out_b,
    output logic data_strobe_out_oe,
    output logic auto_feed_out_b,
    output logic auto_feed_out_oe,
    output logic select_in_out_b,
    output logic select_in_out_oe,
    output logic init_out_b,
    output logic [15:0] irq_lines_o,
    output logic [15:0] irq_lines_oe,
    output logic [2:0] dma_req_o,
    output logic data_fifo_full,
    output ppm_pkg::ppm_mode_t active_mode
);

    localparam int SL_N = 1 << SL_IDX_W;

    if (SL_IDX_W < 2 || SL_IDX_W > 7) begin : g_bad_idx
        $error("ppm_port second-level index width must be 2 to 7");
    end

    if (FIFO_DEPTH != 4) begin : g_bad_fifo
        $error("ppm_port data buffer depth must be 4");
    end

    // ==========================================================
    // Pin synchronisers.
    ppm_pkg::ppm_host_bus_t host_s;
    ppm_pkg::ppm_status_pins_t stat_s;
    logic [7:0] lines_s;

    ppm_sync #(.W($bits(ppm_pkg::ppm_host_bus_t)),
        .RST_VAL(ppm_pkg::HOST_IDLE)) u_host_sync (.clk(clk),
        .rst_b(rst_b), .ce(ce), .din(host_pins), .dout(host_s));

    ppm_sync #(.W($bits(ppm_pkg::ppm_status_pins_t) + 8)) u_pin_sync (
        .clk(clk), .rst_b(rst_b), .ce(ce),
        .din({status_pins, port_data_lines_i}), .dout({stat_s, lines_s}));

    // ==========================================================
    // Strobe edges, address decode and routing.
    logic rd_dly_q, rd_dly_d, wr_dly_q, wr_dly_d;
    logic rd_pulse, wr_pulse, port_on, dack_on, io_wr, dma_wr;
    logic [15:0] offset;
    logic bidir_mode, dir_in, dyn_cfg;
    logic [7:0] ctrl_q, ctrl_d;

    always_comb begin
        rd_dly_d = ce ? host_s.rd_b : rd_dly_q;
        wr_dly_d = ce ? host_s.wr_b : wr_dly_q;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_dly_q <= 1'b1;
            wr_dly_q <= 1'b1;
        end else begin
            rd_dly_q <= rd_dly_d;
            wr_dly_q <= wr_dly_d;
        end
    end

    // Each falling strobe edge gives a single one-cycle access.
    assign rd_pulse = ce & rd_dly_q & ~host_s.rd_b;
    assign wr_pulse = ce & wr_dly_q & ~host_s.wr_b;
    assign offset = host_s.addr - base_addr;
    assign port_on = function_enable_one;
    assign dack_on = (dma_route < 2'(ppm_pkg::DMA_CHANS)) &
        ~host_s.dack_b[dma_route];
    assign io_wr = wr_pulse & port_on & ~dack_on;
    assign dma_wr = wr_pulse & port_on & dack_on;

    // Dynamic configuration needs bit 4 and a 110 or 111 field.
    assign dyn_cfg = cfg_mode[0] &
        ((cfg_mode[3:1] == ppm_pkg::CFG_DYN_A) |
        (cfg_mode[3:1] == ppm_pkg::CFG_DYN_B));

    // Direction bit counts in every mode but the output-only ones.
    assign bidir_mode = (active_mode != ppm_pkg::PPM_SPP_COMPAT) &
        (active_mode != ppm_pkg::PPM_FIFO_OUT);
    assign dir_in = bidir_mode & ctrl_q[ppm_pkg::CTRL_DIR];

    // ==========================================================
    // Data buffer between host writes and the output latch.
    logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [7:0] fifo_out_data;
    logic data_push;

    assign data_push = dma_wr |
        (io_wr & (offset == ppm_pkg::OFF_DATA));
    assign fifo_out_ready = (active_mode != ppm_pkg::PPM_FIFO_OUT) |
        ~stat_s.busy;
    assign data_fifo_full = ~fifo_in_ready;

    ppm_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (.clk(clk), .rst_b(rst_b),
        .ce(ce), .in_valid(data_push), .in_ready(fifo_in_ready),
        .in_data(host_s.wdata), .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready), .out_data(fifo_out_data));

    // ==========================================================
    // Register file and mode selection.
    logic [7:0] latch_q, latch_d, ecr_q, ecr_d;
    logic [7:0] idx_q, idx_d, rdata_q, rdata_d;
    logic [7:0] sl_q [SL_N];
    logic [7:0] sl_d [SL_N];
    logic [7:0] sl_rd, qual;
    logic rd_oe_q, rd_oe_d, dyn_q, dyn_d, rd_hit;
    ppm_pkg::ppm_mode_t mode_q, mode_d;

    assign qual = sl_q[ppm_pkg::SL_QUAL_IDX[SL_IDX_W-1:0]];
    assign sl_rd = (idx_q < 8'(SL_N)) ? sl_q[idx_q[SL_IDX_W-1:0]] : 8'h00;

    always_comb begin
        latch_d = latch_q;
        ctrl_d = ctrl_q;
        ecr_d = ecr_q;
        idx_d = idx_q;
        sl_d = sl_q;
        rdata_d = rdata_q;
        rd_oe_d = rd_oe_q;
        dyn_d = ce ? dyn_cfg : dyn_q;
        mode_d = mode_q;
        rd_hit = 1'b1;
        // Buffered words move into the output latch.
        if (ce && fifo_out_valid && fifo_out_ready) begin
            latch_d = fifo_out_data;
        end
        // Host writes; status writes fall through untouched.
        if (io_wr) begin
            case (offset)
                ppm_pkg::OFF_CONTROL: ctrl_d = host_s.wdata;
                ppm_pkg::OFF_EXT_CTRL: ecr_d = host_s.wdata;
                ppm_pkg::OFF_SL_INDEX: idx_d = host_s.wdata;
                ppm_pkg::OFF_SL_DATA: begin
                    if (idx_q < 8'(SL_N)) begin
                        sl_d[idx_q[SL_IDX_W-1:0]] = host_s.wdata;
                    end
                end
                default: ctrl_d = ctrl_q;
            endcase
        end
        // Entering dynamic configuration starts the port in ECP.
        if (dyn_cfg && !dyn_q && ce) begin
            ecr_d[7:5] = ppm_pkg::ECR_ECP;
        end
        // Read data is captured at the strobe edge.
        case (offset)
            ppm_pkg::OFF_DATA: rdata_d = dir_in ? lines_s : latch_q;
            ppm_pkg::OFF_STATUS: rdata_d = {~stat_s.busy, stat_s.ack_b,
                stat_s.paper_end, stat_s.select, stat_s.error_b,
                ppm_pkg::STATUS_LOW_ONES};
            ppm_pkg::OFF_CONTROL: rdata_d = {ppm_pkg::CTRL_HIGH_ONES,
                (bidir_mode & (active_mode != ppm_pkg::PPM_SPP_EXT)) ?
                ctrl_q[ppm_pkg::CTRL_DIR] : 1'b1, ctrl_q[4:0]};
            ppm_pkg::OFF_EXT_CTRL: rdata_d = ecr_q;
            ppm_pkg::OFF_SL_INDEX: rdata_d = idx_q;
            ppm_pkg::OFF_SL_DATA: rdata_d = sl_rd;
            default: begin
                rdata_d = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
        if (!rd_pulse) begin
            rdata_d = rdata_q;
        end
        if (rd_pulse) begin
            rd_oe_d = port_on & rd_hit;
        end else if (ce && (host_s.rd_b || !port_on)) begin
            rd_oe_d = 1'b0;
        end
        // Active mode from static codes or extended control.
        if (ce) begin
            if (!dyn_cfg) begin
                case (cfg_mode[3:1])
                    ppm_pkg::CFG_COMPAT: mode_d = ppm_pkg::PPM_SPP_COMPAT;
                    ppm_pkg::CFG_EXT: mode_d = ppm_pkg::PPM_SPP_EXT;
                    ppm_pkg::CFG_EPP17: mode_d = ppm_pkg::PPM_EPP17;
                    ppm_pkg::CFG_EPP19: mode_d = ppm_pkg::PPM_EPP19;
                    default: mode_d = ppm_pkg::PPM_ECP;
                endcase
            end else begin
                case (ecr_q[7:5])
                    ppm_pkg::ECR_COMPAT: mode_d = ppm_pkg::PPM_SPP_COMPAT;
                    ppm_pkg::ECR_EXT: mode_d = ppm_pkg::PPM_SPP_EXT;
                    ppm_pkg::ECR_FIFO: mode_d = ppm_pkg::PPM_FIFO_OUT;
                    ppm_pkg::ECR_EPP: mode_d =
                        qual[ppm_pkg::QUAL_EPP_REV_BIT] ?
                        ppm_pkg::PPM_EPP19 : ppm_pkg::PPM_EPP17;
                    default: mode_d = ppm_pkg::PPM_ECP;
                endcase
            end
        end
    end

    // Register state; data latch resets to zero.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            latch_q <= ppm_pkg::DATA_RST;
            ctrl_q <= ppm_pkg::CTRL_RST;
            ecr_q <= ppm_pkg::EXT_CTRL_RST;
            idx_q <= 8'h00;
            for (int i = 0; i < SL_N; i++) begin
                sl_q[i] <= ppm_pkg::SL_RST;
            end
            rdata_q <= 8'h00;
            rd_oe_q <= 1'b0;
            dyn_q <= 1'b0;
            mode_q <= ppm_pkg::PPM_ECP;
        end else begin
            latch_q <= latch_d;
            ctrl_q <= ctrl_d;
            ecr_q <= ecr_d;
            idx_q <= idx_d;
            sl_q <= sl_d;
            rdata_q <= rdata_d;
            rd_oe_q <= rd_oe_d;
            dyn_q <= dyn_d;
            mode_q <= mode_d;
        end
    end

    assign active_mode = mode_q;
    assign host_data_o = rdata_q;
    assign host_data_oe = rd_oe_q;
    assign port_data_lines_o = latch_q;

    // ==========================================================
    // Pin drivers: handshake lines float and init is low in reset.
    logic lines_oe_q, lines_oe_d, hs_oe_q, hs_oe_d, init_q, init_d;
    logic irq_q, irq_d, irq_oe_q, irq_oe_d, irq_ok;
    logic [2:0] dreq_q, dreq_d;

    assign irq_ok = (irq_route != ppm_pkg::IRQ_NONE) &
        (irq_route != ppm_pkg::IRQ_BAR_A) &
        (irq_route != ppm_pkg::IRQ_BAR_B);

    always_comb begin
        lines_oe_d = lines_oe_q;
        hs_oe_d = hs_oe_q;
        init_d = init_q;
        irq_d = irq_q;
        irq_oe_d = irq_oe_q;
        dreq_d = dreq_q;
        if (ce) begin
            lines_oe_d = port_on & ~dir_in;
            hs_oe_d = port_on;
            init_d = port_on & ctrl_q[ppm_pkg::CTRL_INIT];
            irq_d = ~stat_s.ack_b;
            irq_oe_d = port_on & irq_ok &
                ctrl_q[ppm_pkg::CTRL_IRQ_EN];
            dreq_d = 3'h0;
            if (port_on && dack_on == 1'b0 &&
                active_mode == ppm_pkg::PPM_FIFO_OUT &&
                dma_route < 2'(ppm_pkg::DMA_CHANS)) begin
                dreq_d[dma_route] = fifo_in_ready;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lines_oe_q <= 1'b0;
            hs_oe_q <= 1'b0;
            init_q <= 1'b0;
            irq_q <= 1'b0;
            irq_oe_q <= 1'b0;
            dreq_q <= 3'h0;
        end else begin
            lines_oe_q <= lines_oe_d;
            hs_oe_q <= hs_oe_d;
            init_q <= init_d;
            irq_q <= irq_d;
            irq_oe_q <= irq_oe_d;
            dreq_q <= dreq_d;
        end
    end

    // Strobe, auto-feed and select-in pins are the inverse of their control bits; init follows its bit while the port is enabled, else stays low.
    assign port_data_lines_oe = lines_oe_q;
    assign data_strobe_out_b = ~ctrl_q[ppm_pkg::CTRL_STROBE];
    assign auto_feed_out_b = ~ctrl_q[ppm_pkg::CTRL_AUTOFEED];
    assign select_in_out_b = ~ctrl_q[ppm_pkg::CTRL_SELECT];
    assign data_strobe_out_oe = hs_oe_q;
    assign auto_feed_out_oe = hs_oe_q;
    assign select_in_out_oe = hs_oe_q;
    assign init_out_b = init_q;
    assign dma_req_o = dreq_q;

    // Only the routed interrupt line is ever enabled.
    always_comb begin
        irq_lines_o = 16'h0000;
        irq_lines_oe = 16'h0000;
        irq_lines_o[irq_route] = irq_q;
        irq_lines_oe[irq_route] = irq_oe_q;
    end

    // ==========================================================
    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    hole_undriven_a: assert property (
        rd_pulse && offset == ppm_pkg::OFF_HOLE |=> !host_data_oe)
        else $error("offset 3 read drove the bus");
    static_mode_a: assert property (
        ce && !dyn_cfg && cfg_mode[3:1] == ppm_pkg::CFG_EPP19
        |=> active_mode == ppm_pkg::PPM_EPP19)
        else $error("static code 011 did not give EPP 1.9");
    dyn_epp_a: assert property (
        ce && dyn_cfg && ecr_q[7:5] == ppm_pkg::ECR_EPP
        && !qual[ppm_pkg::QUAL_EPP_REV_BIT]
        |=> active_mode == ppm_pkg::PPM_EPP17)
        else $error("EPP qualifier 0 did not give revision 1.7");
    static_nofifo_a: assert property (
        ce && !dyn_cfg |=> active_mode != ppm_pkg::PPM_FIFO_OUT)
        else $error("FIFO mode reached without dynamic configuration");
    ext_input_a: assert property (
        ce && active_mode == ppm_pkg::PPM_SPP_EXT &&
        ctrl_q[ppm_pkg::CTRL_DIR] |=> !port_data_lines_oe)
        else $error("data lines driven with direction set to input");
    compat_drive_a: assert property (
        ce && port_on && active_mode == ppm_pkg::PPM_SPP_COMPAT
        |=> port_data_lines_oe)
        else $error("compatible mode did not drive data lines");
    one_access_a: assert property (
        wr_pulse |=> !wr_pulse ##1 !wr_pulse)
        else $error("one strobe gave two write accesses");
    status_write_a: assert property (
        io_wr && offset == ppm_pkg::OFF_STATUS
        |=> $stable(ctrl_q) && $stable(ecr_q) && $stable(idx_q))
        else $error("status write changed port state");
    disabled_quiet_a: assert property (
        ce && !port_on ##1 !port_on |-> !host_data_oe && !irq_oe_q)
        else $error("disabled port answered or drove interrupt");
    init_follow_a: assert property (
        ce && port_on ##1 port_on |-> init_out_b ==
        $past(ctrl_q[ppm_pkg::CTRL_INIT]))
        else $error("init output does not follow control bit");

endmodule

`default_nettype wire

//--- ppm_printer.sv
`default_nettype none

// ==========================================================
// Printer model: reports status and drives the data pins.
module ppm_printer (
    input wire logic busy,
    input wire logic [7:0] drive_val,
    input wire logic [7:0] lines_o,
    input wire logic lines_oe,
    output ppm_pkg::ppm_status_pins_t status,
    output logic [7:0] lines_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // Online, paper loaded, no error, no acknowledge pending.
    assign status = '{busy: busy, ack_b: 1'b1, paper_end: 1'b0,
        select: 1'b1, error_b: 1'b1};
    // Pins show the port's drive, else the printer's own byte.
    assign lines_i = lines_oe ? lines_o : drive_val;
endmodule

`default_nettype wire

//--- ppm_port_bench.sv
`default_nettype none

// ==========================================================
// Host accesses to the port, checked against a printer model.
module ppm_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic function_enable_one = 1'b1;
    logic busy = 1'b0;
    logic [3:0] cfg_mode = 4'hd;
    ppm_pkg::ppm_host_bus_t host_pins = ppm_pkg::HOST_IDLE;
    ppm_pkg::ppm_status_pins_t status_pins;
    ppm_pkg::ppm_mode_t active_mode;
    logic [7:0] host_data_o, port_data_lines_i, port_data_lines_o, rd;
    logic host_data_oe, port_data_lines_oe, data_fifo_full, init_out_b;
    logic data_strobe_out_oe, auto_feed_out_oe, select_in_out_oe, roe;
    logic st_b, af_b, sl_b;
    logic [15:0] irq_oe;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    ppm_pkg::ppm_mode_t st_exp [4] = '{ppm_pkg::PPM_SPP_COMPAT,
        ppm_pkg::PPM_SPP_EXT, ppm_pkg::PPM_EPP17, ppm_pkg::PPM_EPP19};
    ppm_pkg::ppm_mode_t dy_exp [4] = '{ppm_pkg::PPM_SPP_COMPAT,
        ppm_pkg::PPM_SPP_EXT, ppm_pkg::PPM_FIFO_OUT, ppm_pkg::PPM_ECP};
    // Port under test, with fixed base address and routing.
    ppm_port ppm_port_inst (
        .clk, .rst_b, .ce(1'b1), .base_addr(16'h0378), .cfg_mode,
        .function_enable_one, .irq_route(4'h5), .dma_route(2'h3),
        .host_pins, .host_data_o, .host_data_oe, .status_pins,
        .port_data_lines_i, .port_data_lines_o, .port_data_lines_oe,
        .data_strobe_out_b(st_b), .data_strobe_out_oe,
        .auto_feed_out_b(af_b), .auto_feed_out_oe,
        .select_in_out_b(sl_b), .select_in_out_oe,
        .init_out_b, .irq_lines_o(), .irq_lines_oe(irq_oe), .dma_req_o(),
        .data_fifo_full, .active_mode);
    // Printer on the far side of the data and status pins.
    ppm_printer ppm_printer_inst (.busy, .drive_val(8'h3c),
        .lines_o(port_data_lines_o), .lines_oe(port_data_lines_oe),
        .status(status_pins), .lines_i(port_data_lines_i));
    // Clock, and a guard that cuts a hung run short.
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            test_done;
        end
    end
    // One host access; the strobe is held well past the sync delay.
    task acc(input logic w, input logic [15:0] o, input logic [7:0] d);
        host_pins.addr = 16'h0378 + o;
        host_pins.wdata = d;
        repeat (3) @(posedge clk);
        #1;
        if (w) host_pins.wr_b = 1'b0;
        else host_pins.rd_b = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        rd = host_data_o;
        roe = host_data_oe;
        host_pins.wr_b = 1'b1;
        host_pins.rd_b = 1'b1;
        repeat (6) @(posedge clk);
        #1;
    endtask
    // Byte and mode comparisons; mismatches are printed and counted.
    task chk(input string n, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask
    task chm(input ppm_pkg::ppm_mode_t e);
        chk("mode", {5'h00, e}, {5'h00, active_mode});
    endtask
    // Prints the counts and the verdict, then ends the run.
    task test_done;
        $display("checks %0d failures %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Main sequence of register accesses and checks.
    initial begin
        repeat (10) @(posedge clk);
        #1;
        chk("rst_pins", 8'h00, {4'h0, init_out_b, data_strobe_out_oe,
            auto_feed_out_oe, select_in_out_oe});
        chk("rst_irq", 8'h00, irq_oe[7:0]);
        rst_b = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chm(ppm_pkg::PPM_ECP);
        for (int i = 0; i < 4; i++) begin
            cfg_mode = {i[2:0], 1'b0};
            repeat (3) @(posedge clk);
            #1;
            chm(st_exp[i]);
        end
        cfg_mode = 4'hf;
        repeat (3) @(posedge clk);
        #1;
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, 16'h0402, {i[2:0], 5'h00});
            chm(dy_exp[i]);
        end
        acc(1'b1, 16'h0403, ppm_pkg::SL_QUAL_IDX);
        acc(1'b1, 16'h0404, 8'h10);
        acc(1'b1, 16'h0402, 8'h80);
        chm(ppm_pkg::PPM_EPP19);
        acc(1'b1, 16'h0404, 8'h00);
        chm(ppm_pkg::PPM_EPP17);
        acc(1'b1, 16'h0402, 8'h00);
        acc(1'b0, 16'h0000, 8'h00);
        chk("data_rst", 8'h00, rd);
        acc(1'b1, 16'h0002, 8'h2b);
        acc(1'b1, 16'h0000, 8'ha5);
        acc(1'b0, 16'h0000, 8'h00);
        chk("cmp_rd", 8'ha5, rd);
        chk("cmp_oe", 8'h01, {7'h00, port_data_lines_oe});
        chk("ctl_pins", 8'h00, {4'h0, init_out_b, sl_b, af_b, st_b});
        acc(1'b1, 16'h0402, 8'h20);
        acc(1'b1, 16'h0000, 8'h5a);
        acc(1'b0, 16'h0000, 8'h00);
        chk("ext_in", 8'h3c, rd);
        chk("ext_oe", 8'h00, {7'h00, port_data_lines_oe});
        acc(1'b1, 16'h0002, 8'h00);
        acc(1'b1, 16'h0001, 8'h1f);
        acc(1'b0, 16'h0000, 8'h00);
        chk("ext_rd", 8'h5a, rd);
        chk("ext_drv", 8'h01, {7'h00, port_data_lines_oe});
        chk("ext_out", 8'h5a, port_data_lines_o);
        acc(1'b0, 16'h0002, 8'h00);
        chk("ctrl", 8'he0, rd);
        acc(1'b0, 16'h0001, 8'h00);
        chk("status", 8'hdf, rd);
        acc(1'b0, 16'h0003, 8'h00);
        chk("hole_oe", 8'h00, {7'h00, roe});
        busy = 1'b1;
        acc(1'b1, 16'h0402, 8'h40);
        for (int i = 0; i < 5; i++) begin
            acc(1'b1, 16'h0000, 8'h10 + i[7:0]);
            chk("full", {7'h00, i > 2}, {7'h00, data_fifo_full});
        end
        busy = 1'b0;
        for (int k = 0; k < 200 && port_data_lines_o !== 8'h13; k++) begin
            @(posedge clk);
            #1;
        end
        chk("drain", 8'h13, port_data_lines_o);
        function_enable_one = 1'b0;
        acc(1'b0, 16'h0001, 8'h00);
        chk("off_oe", 8'h00, {7'h00, roe});
        chk("drop", 8'h13, port_data_lines_o);
        test_done;
    end
endmodule

`default_nettype wire
